// [rtl/servo_pkg.sv]
/*
  Shared constants and types of the servo host port: command layout,
  serial framing timing, clock divider settings, actuator stream rate.
  Assumes a 20 MHz core clock; nothing else.
*/
package servo_pkg;

  // Core clock and its period
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;

  // Idle time on the framing line that closes a transaction
  localparam int FRAME_GAP_NS  = 10_000;
  // Least time, so rounded up
  localparam int FRAME_GAP_CYC =
    (FRAME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W         = 8;

  // Byte framing
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam int         BYTE_W      = 8;
  localparam logic [2:0] MAX_WR_BYTES = 3'h7;
  localparam logic [2:0] MAX_RD_BYTES = 3'h5;

  // Command codes
  localparam logic [3:0] CODE_CLOCK  = 4'h0;
  localparam logic [3:0] CODE_FOCUS  = 4'h1;
  localparam logic [3:0] CODE_RADIAL = 4'h2;
  localparam logic [3:0] CODE_SLEDGE = 4'h3;
  localparam logic [3:0] CODE_LASER  = 4'h4;

  // Divisor selections and reset values
  localparam logic [1:0] DIV_SEL_2   = 2'h0;
  localparam logic [1:0] DIV_SEL_3   = 2'h1;
  localparam logic [1:0] DIV_SEL_4   = 2'h2;
  localparam logic [1:0] DIV_SEL_RST = 2'h2;
  localparam logic       DBL_RST     = 1'b0;
  localparam logic [2:0] DIV_N_2     = 3'h2;
  localparam logic [2:0] DIV_N_3     = 3'h3;
  localparam logic [2:0] DIV_N_4     = 3'h4;

  // Actuator stream: fractional rate generator
  localparam int ACT_RATE_HZ = 1_058_400;
  localparam int NCO_DIV     = 800;
  localparam int NCO_W       = 15;
  localparam logic [NCO_W-1:0] NCO_STEP = NCO_W'(ACT_RATE_HZ / NCO_DIV);
  localparam logic [NCO_W-1:0] NCO_MOD  = NCO_W'(CLK_HZ / NCO_DIV);
  localparam logic [7:0] ACT_LEVEL_RST  = 8'h80;
  localparam int         ACT_NUM        = 3;

  // Laser reset state: off
  localparam logic LASER_ON_RST = 1'b0;

  // Command byte: direction, write count, code
  typedef struct packed {
    logic       rd;
    logic [2:0] cnt;
    logic [3:0] code;
  } cmd_type;

  // Clock configuration data byte
  typedef struct packed {
    logic [4:0] rsvd;
    logic       dbl;
    logic [1:0] div_sel;
  } clk_cfg_type;

  // One written data byte handed to the servo core
  typedef struct packed {
    logic [3:0] code;
    logic [2:0] index;
    logic [7:0] data;
  } wr_beat_type;

  // Port state, one-hot
  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_WR  = 3'b010,
    ST_RD  = 3'b100
  } port_state_type;

endpackage

// [rtl/clk_divider.sv]
/*
  System clock divider and clock buffer output select.
  Assumes the core clock stands for the oscillator; outputs are flops.
*/
`timescale 1ns/1ps
module clk_divider (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Configuration
  input  wire logic [1:0] div_sel_i,
  input  wire logic       dbl_i,
  // Clocks out
  output logic            sys_clk_o,
  output logic            buf_clk_o
);

  logic [2:0] cnt_ff;   // Phase within one system period
  logic [2:0] div_n;    // Selected divisor
  logic [2:0] half_n;   // High phase length
  logic [2:0] nxt_cnt;  // Next phase

  // Divide by 2, 3 or 4; unknown code falls back to 4
  assign div_n  = (div_sel_i == servo_pkg::DIV_SEL_2) ? servo_pkg::DIV_N_2 :
                  (div_sel_i == servo_pkg::DIV_SEL_3) ? servo_pkg::DIV_N_3 :
                  servo_pkg::DIV_N_4;
  assign half_n = div_n >> 1;
  // Wrap also covers a divisor shrinking mid-period
  assign nxt_cnt = (cnt_ff + 3'h1 >= div_n) ? 3'h0 : cnt_ff + 3'h1;

  // Phase counter and output flops
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_ff    <= 3'h0;
      sys_clk_o <= 1'b0;
      buf_clk_o <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      sys_clk_o <= (nxt_cnt < half_n);
      // Doubled rate follows inverted phase bit 0, so only divide by 4 yields twice the rate
      buf_clk_o <= dbl_i ? ~nxt_cnt[0] : (nxt_cnt < half_n);
    end
  end

endmodule

// [rtl/noise_shaper.sv]
/*
  First-order one-bit noise shaper for one actuator channel.
  Assumes tick_i is a one-cycle strobe at the stream rate.
*/
`timescale 1ns/1ps
module noise_shaper #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  // Level and rate
  input  wire logic [W-1:0] level_i,
  input  wire logic         tick_i,
  // One-bit stream
  output logic              bit_o
);

  logic [W-1:0] acc_ff;  // Error accumulator
  logic [W:0]   sum;     // Accumulator plus level, carry on top

  assign sum = {1'b0, acc_ff} + {1'b0, level_i};

  // Carry out is the stream bit, remainder feeds back
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      acc_ff <= '0;
      bit_o  <= 1'b0;
    end else if (tick_i) begin
      acc_ff <= sum[W-1:0];
      bit_o  <= sum[W];
    end
  end

endmodule

// [rtl/servo_host_port.sv]
/*
  Serial command port of the servo processor with clocking, actuator
  output stages and laser switch.
  Assumes serial pins sampled on the core clock, serial clock idling low
  and much slower than the core clock.
*/
// Operation
// - Serial clock is asynchronous to device clock
// - Framing line ends bytes, steers direction
// - Eight-bit words, most significant bit first
// - Data sampled on serial clock rising edge
// - Data line bidirectional, device drives reads
// - One command byte, up to seven data
// - First byte is command, picks direction
// - Write count taken from command byte
// - Reads return zero to five bytes
// - Actuators are one-bit streams at 1.0584 MHz
// - Reset low puts actuator drivers high-impedance
// - System clock is oscillator divided 2/3/4
// - Supports 8.4672, 11.2896, 16.9344 MHz sources; code assumes a 20 MHz core clock for the stream rate
// - Buffer output gives system or double clock; code doubles only at divide by 4
// - Reset initialises all logic and outputs
// - Laser switch open-drain, low means off
`timescale 1ns/1ps
module servo_host_port #(
  parameter int GAP_CYC = servo_pkg::FRAME_GAP_CYC
) (
  // Clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  // Serial bus
  input  wire logic                     serial_clock_line_i,
  input  wire logic                     serial_framing_line_i,
  input  wire logic                     serial_data_line_i,
  output logic                          serial_data_line_o,
  output logic                          serial_data_line_oe_o,
  // Servo core side
  input  wire logic [39:0]              rd_bytes_i,
  output servo_pkg::wr_beat_type        wr_beat_o,
  output logic                          wr_valid_o,
  // Actuator stages
  output logic [servo_pkg::ACT_NUM-1:0] actuator_o,
  output logic [servo_pkg::ACT_NUM-1:0] actuator_oe_o,
  // Laser switch
  output logic                          laser_drive_switch_o,
  output logic                          laser_drive_switch_oe_o,
  // Clocks
  output logic                          sys_clk_o,
  output logic                          clock_buffer_output_o
);

  // Synchronisers: meta stage read only by the next stage
  logic [2:0] meta_ff;     // {clock, framing, data} first stage
  logic [2:0] sync_ff;     // Second stage
  logic [1:0] prev_ff;     // Delayed {clock, framing}
  // Port state
  servo_pkg::port_state_type st_ff;
  servo_pkg::port_state_type nxt_st;
  logic [3:0]  bit_cnt_ff;  // Bits in current byte
  logic [7:0]  shift_ff;    // Received byte
  logic [7:0]  tx_ff;       // Byte being returned
  logic [39:0] rd_buf_ff;   // Read bytes captured at command
  logic [2:0]  remain_ff;   // Write bytes still due
  logic [2:0]  index_ff;    // Data byte number
  logic [3:0]  code_ff;     // Active command code
  logic [servo_pkg::GAP_W-1:0] gap_ff; // Framing idle time
  // Configuration
  logic [1:0]  div_sel_ff;  // Divisor select
  logic        dbl_ff;      // Doubled buffer clock
  logic [7:0]  lvl_ff [servo_pkg::ACT_NUM]; // Actuator levels
  // Stream rate generator
  logic [servo_pkg::NCO_W-1:0] nco_ff;
  logic [servo_pkg::NCO_W:0]   nco_sum;
  logic                        tick;

  // Decoded events
  logic scl_rise, scl_fall, frm_low, frm_rise, frm_fall;
  logic byte_ok, gap_hit, rd_load, wr_take, cmd_take;
  servo_pkg::cmd_type     cmd;
  servo_pkg::clk_cfg_type cfg_in;
  servo_pkg::clk_cfg_type cfg_now;

  assign scl_rise = sync_ff[2] & ~prev_ff[1];
  assign scl_fall = ~sync_ff[2] & prev_ff[1];
  assign frm_low  = ~sync_ff[1];
  assign frm_rise = sync_ff[1] & ~prev_ff[0];
  assign frm_fall = ~sync_ff[1] & prev_ff[0];
  // A byte counts with eight or more bits; the bit count stops at eight
  assign byte_ok  = frm_rise && (bit_cnt_ff == servo_pkg::BYTE_BITS);
  assign gap_hit  = (gap_ff == servo_pkg::GAP_W'(GAP_CYC));
  assign cmd      = servo_pkg::cmd_type'(shift_ff);
  assign cfg_in   = servo_pkg::clk_cfg_type'(shift_ff);
  assign cfg_now  = '{rsvd: '0, dbl: dbl_ff, div_sel: div_sel_ff};
  assign cmd_take = byte_ok && (st_ff == servo_pkg::ST_CMD);
  assign wr_take  = byte_ok && (st_ff == servo_pkg::ST_WR);
  assign rd_load  = frm_fall && (st_ff == servo_pkg::ST_RD)
                    && (index_ff < servo_pkg::MAX_RD_BYTES);
  assign nco_sum  = {1'b0, nco_ff} + {1'b0, servo_pkg::NCO_STEP};
  assign tick     = (nco_sum >= {1'b0, servo_pkg::NCO_MOD});

  // Pin synchronisers and edge history
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      // Idle levels: clock low, framing high, so no false edge
      meta_ff <= 3'h2;
      sync_ff <= 3'h2;
      prev_ff <= 2'h1;
    end else begin
      meta_ff <= {serial_clock_line_i, serial_framing_line_i,
                  serial_data_line_i};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff[2:1];
    end
  end

  // Transaction state
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      servo_pkg::ST_CMD: begin
        if (cmd_take && cmd.rd) begin
          nxt_st = servo_pkg::ST_RD;
        end else if (cmd_take && (cmd.cnt != 3'h0)) begin
          nxt_st = servo_pkg::ST_WR;
        end
      end
      servo_pkg::ST_WR: begin
        if (wr_take && (remain_ff == 3'h1)) begin
          nxt_st = servo_pkg::ST_CMD;
        end
      end
      servo_pkg::ST_RD: begin
        if (byte_ok &&
            (index_ff + 3'h1 == servo_pkg::MAX_RD_BYTES)) begin
          nxt_st = servo_pkg::ST_CMD;
        end
      end
      default: nxt_st = servo_pkg::ST_CMD;
    endcase
    // Framing idle closes early-ended transfers
    if (gap_hit) begin
      nxt_st = servo_pkg::ST_CMD;
    end
  end

  // Bit shifter, byte bookkeeping
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_ff      <= servo_pkg::ST_CMD;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      remain_ff  <= 3'h0;
      index_ff   <= 3'h0;
      code_ff    <= 4'h0;
      gap_ff     <= '0;
    end else begin
      st_ff <= nxt_st;
      // Sample on rising serial clock, MSB enters first
      if (scl_rise && frm_low) begin
        shift_ff   <= {shift_ff[6:0], sync_ff[0]};
        if (bit_cnt_ff != servo_pkg::BYTE_BITS) begin
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
      end else if (frm_rise) begin
        bit_cnt_ff <= 4'h0;
      end
      // Framing idle counter
      if (frm_low) begin
        gap_ff <= '0;
      end else if (!gap_hit) begin
        gap_ff <= gap_ff + 1'b1;
      end
      if (cmd_take) begin
        code_ff   <= cmd.code;
        remain_ff <= cmd.cnt;
        index_ff  <= 3'h0;
      end else if (wr_take) begin
        remain_ff <= remain_ff - 3'h1;
        index_ff  <= index_ff + 3'h1;
      end else if (byte_ok && st_ff == servo_pkg::ST_RD) begin
        index_ff  <= index_ff + 3'h1;
      end
    end
  end

  // Read path: capture, load, shift out on falling clock
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_buf_ff             <= 40'h0;
      tx_ff                 <= 8'h00;
      serial_data_line_o    <= 1'b0;
      serial_data_line_oe_o <= 1'b0;
    end else begin
      if (cmd_take && cmd.rd) begin
        rd_buf_ff <= (cmd.code == servo_pkg::CODE_CLOCK) ?
                     {cfg_now, 32'h0} : rd_bytes_i;
      end else if (rd_load) begin
        rd_buf_ff <= {rd_buf_ff[31:0], 8'h00};
      end
      if (rd_load) begin
        tx_ff                 <= {rd_buf_ff[38:32], 1'b0};
        serial_data_line_o    <= rd_buf_ff[39];
        serial_data_line_oe_o <= 1'b1;
      end else if (scl_fall && frm_low && st_ff == servo_pkg::ST_RD) begin
        tx_ff              <= {tx_ff[6:0], 1'b0};
        serial_data_line_o <= tx_ff[7];
      end else if (!frm_low || st_ff != servo_pkg::ST_RD) begin
        serial_data_line_oe_o <= 1'b0;
      end
    end
  end

  // Written data: configuration and hand-over to the servo core
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      div_sel_ff  <= servo_pkg::DIV_SEL_RST;
      dbl_ff      <= servo_pkg::DBL_RST;
      laser_drive_switch_oe_o <= ~servo_pkg::LASER_ON_RST;
      wr_valid_o  <= 1'b0;
      wr_beat_o   <= '0;
      for (int i = 0; i < servo_pkg::ACT_NUM; i++) begin
        lvl_ff[i] <= servo_pkg::ACT_LEVEL_RST;
      end
    end else begin
      wr_valid_o <= wr_take;
      if (wr_take) begin
        wr_beat_o <= '{code: code_ff, index: index_ff, data: shift_ff};
      end
      if (wr_take && code_ff == servo_pkg::CODE_CLOCK) begin
        div_sel_ff <= cfg_in.div_sel;
        dbl_ff     <= cfg_in.dbl;
      end
      if (wr_take && code_ff == servo_pkg::CODE_LASER) begin
        laser_drive_switch_oe_o <= ~shift_ff[0];
      end
      for (int i = 0; i < servo_pkg::ACT_NUM; i++) begin
        if (wr_take && code_ff == 4'(i + 1)) begin
          lvl_ff[i] <= shift_ff;
        end
      end
    end
  end

  // Stream rate generator and output enables
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      nco_ff               <= '0;
      actuator_oe_o        <= '0;
      laser_drive_switch_o <= 1'b0;
    end else begin
      nco_ff <= tick ? servo_pkg::NCO_W'(nco_sum - servo_pkg::NCO_MOD)
                     : nco_sum[servo_pkg::NCO_W-1:0];
      actuator_oe_o        <= '1;
      laser_drive_switch_o <= 1'b0;
    end
  end

  // Focus, radial and sledge streams
  for (genvar g = 0; g < servo_pkg::ACT_NUM; g++) begin : g_act
    noise_shaper #(.W(8)) u_shaper (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .level_i    (lvl_ff[g]),
      .tick_i     (tick),
      .bit_o      (actuator_o[g])
    );
  end

  // System clock and buffer output
  clk_divider u_div (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .div_sel_i  (div_sel_ff),
    .dbl_i      (dbl_ff),
    .sys_clk_o  (sys_clk_o),
    .buf_clk_o  (clock_buffer_output_o)
  );

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_hiz: assert property (disable iff (1'b0)
    !rst_n_i |=> (actuator_oe_o == '0))
    else $error("actuator drivers not released in reset");
  a_clk_default: assert property (disable iff (1'b0)
    !rst_n_i |=> (div_sel_ff == servo_pkg::DIV_SEL_RST) && !dbl_ff)
    else $error("clock settings not at defaults after reset");
  a_cmd_read: assert property (
    cmd_take && cmd.rd && !gap_hit |=> st_ff == servo_pkg::ST_RD)
    else $error("read command did not enter read phase");
  a_wr_count: assert property (
    cmd_take && !cmd.rd && cmd.cnt != 3'h0 && !gap_hit
    |=> st_ff == servo_pkg::ST_WR && remain_ff == $past(cmd.cnt))
    else $error("write count not taken from command");
  a_wr_only: assert property (
    wr_valid_o |-> $past(st_ff, 2) == servo_pkg::ST_WR)
    else $error("data beat outside write phase");
  a_rd_limit: assert property (
    st_ff == servo_pkg::ST_RD |-> index_ff < servo_pkg::MAX_RD_BYTES)
    else $error("more than five read bytes");
  a_msb_first: assert property (
    rd_load |=> serial_data_line_o == $past(rd_buf_ff[39])
                && serial_data_line_oe_o)
    else $error("read byte not started at its top bit");
  a_sample_rise: assert property (
    scl_rise && frm_low |=> shift_ff[0] == $past(sync_ff[0]))
    else $error("data not sampled on rising clock");
  a_laser_od: assert property (
    wr_take && code_ff == servo_pkg::CODE_LASER
    |=> laser_drive_switch_oe_o == !$past(shift_ff[0])
        && !laser_drive_switch_o)
    else $error("laser switch not open-drain");
  a_tick_space: assert property (
    tick |=> !tick [*8])
    else $error("stream tick too frequent");

  c_write: cover property (wr_take && remain_ff == 3'h1);
  c_read5: cover property (byte_ok && st_ff == servo_pkg::ST_RD
                           && index_ff == 3'h4);
  c_laser: cover property (wr_take && code_ff == servo_pkg::CODE_LASER);
  c_early: cover property (gap_hit && st_ff == servo_pkg::ST_RD);

endmodule

// [verif/host_mcu_model.sv]
/*
  Host microcontroller model for the three-line serial bus.
  Assumes the bench calls its tasks; core clock paces steps and the undriven data line toggle.
*/
`timescale 1ns/1ps
module host_mcu_model (
  // Pacing clock
  input  wire logic core_clk_i,
  // Device data drive
  input  wire logic dev_data_i,
  input  wire logic dev_oe_i,
  // Serial bus
  output logic      serial_clock_line_o,
  output logic      serial_framing_line_o,
  output logic      serial_data_line_o
);
  logic host_d  = 1'b0; // Host data bit
  logic host_oe = 1'b0; // Host drives data
  logic last_q  = 1'b0; // Last wire level

  // Wire level; an undriven line toggles every cycle
  assign serial_data_line_o = dev_oe_i ? dev_data_i :
                              host_oe ? host_d : ~last_q;

  // Remember the wire level
  always @(posedge core_clk_i) begin
    last_q <= serial_data_line_o;
  end

  // Idle bus: framing high, clock low
  initial begin
    serial_clock_line_o   = 1'b0;
    serial_framing_line_o = 1'b1;
  end

  // Wait n core edges, then step off the edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask

  // Send top n bits of a byte, MSB first, then close the byte
  task automatic send_bits(input logic [7:0] b, input int n);
    serial_framing_line_o = 1'b0;
    host_oe = 1'b1;
    for (int i = 7; i > 7 - n; i--) begin
      host_d = b[i];
      step(8);
      serial_clock_line_o = 1'b1;
      step(8);
      serial_clock_line_o = 1'b0;
    end
    step(8);
    host_oe = 1'b0;
    serial_framing_line_o = 1'b1;
    step(8);
  endtask

  // Clock one byte out of the device, sampled on rising edges
  task automatic recv_byte(output logic [7:0] b);
    serial_framing_line_o = 1'b0;
    step(8);
    for (int i = 7; i >= 0; i--) begin
      serial_clock_line_o = 1'b1;
      b[i] = serial_data_line_o;
      step(8);
      serial_clock_line_o = 1'b0;
      step(8);
    end
    serial_framing_line_o = 1'b1;
    step(8);
  endtask
endmodule

// [verif/servo_host_port_tb_top.sv]
/*
  Self-checking bench of the servo host port.
  Assumes the package and host_mcu_model are compiled first.
*/
`timescale 1ns/1ps
module servo_host_port_tb_top;
  localparam int GAP = 20; // Shortened framing gap

  logic                    core_clk = 1'b0;  // Core clock
  logic                    rst_n    = 1'b0;  // Reset, active low
  logic                    sck, sfr, sda;    // Serial wires
  logic                    dev_d, dev_oe;    // Device data drive
  logic [39:0]             rd_bytes = '0;    // Read source
  servo_pkg::wr_beat_type  wr_beat;          // Written beat
  logic                    wr_valid;         // Beat strobe
  logic [2:0]              act, act_oe;      // Actuator stages
  logic                    laser_d, laser_oe; // Laser switch
  logic                    sys_clk, buf_clk; // Clock outputs
  int                      fail_count = 0;   // Mismatches
  int                      n_compared = 0;   // Comparisons
  int                      wr_count   = 0;   // Beats seen
  logic [14:0]             last_beat;        // Last beat seen

  servo_host_port #(.GAP_CYC(GAP)) dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n),
    .serial_clock_line_i(sck), .serial_framing_line_i(sfr),
    .serial_data_line_i(sda), .serial_data_line_o(dev_d),
    .serial_data_line_oe_o(dev_oe), .rd_bytes_i(rd_bytes),
    .wr_beat_o(wr_beat), .wr_valid_o(wr_valid),
    .actuator_o(act), .actuator_oe_o(act_oe),
    .laser_drive_switch_o(laser_d),
    .laser_drive_switch_oe_o(laser_oe),
    .sys_clk_o(sys_clk), .clock_buffer_output_o(buf_clk));

  host_mcu_model host (
    .core_clk_i(core_clk), .dev_data_i(dev_d), .dev_oe_i(dev_oe),
    .serial_clock_line_o(sck), .serial_framing_line_o(sfr),
    .serial_data_line_o(sda));

  // 20 MHz clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // Collect written beats
  always @(posedge core_clk) begin
    if (wr_valid === 1'b1) begin
      wr_count++;
      last_beat = wr_beat;
    end
  end

  // Compare and count
  task automatic check(input string what, input logic [39:0] seen,
                       input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Core cycles between two rising edges of a clock output
  task automatic period(input bit use_buf, output int n);
    int   edges;
    logic prev;
    logic cur;
    edges = 0;
    n = 0;
    prev = 1'b1;
    for (int i = 0; i < 40 && edges < 2; i++) begin
      @(posedge core_clk);
      #2;
      cur = use_buf ? buf_clk : sys_clk;
      if (prev === 1'b0 && cur === 1'b1) edges++;
      if (edges == 1) n++;
      prev = cur;
    end
  endtask

  // Command plus one data byte, then idle gap
  task automatic wr1(input logic [7:0] c, input logic [7:0] d);
    host.send_bits(c, 8);
    host.send_bits(d, 8);
    host.step(GAP + 5);
  endtask

  // Reset values and tri-state
  task automatic t_reset();
    int n;
    check("act_oe in reset", act_oe, 3'h0);
    check("laser_oe in reset", laser_oe, 1'b1);
    check("laser_d", laser_d, 1'b0);
    rst_n = 1'b1;
    host.step(3);
    check("act_oe after", act_oe, 3'h7);
    period(0, n);
    check("sys period rst", n, 4);
    period(1, n);
    check("buf period rst", n, 4);
    $display("test reset done");
  endtask

  // Divisors, doubled buffer, read back
  task automatic t_divisor();
    int          n;
    logic [7:0]  b;
    logic [1:0]  sel [3] = '{servo_pkg::DIV_SEL_2, servo_pkg::DIV_SEL_3,
                             servo_pkg::DIV_SEL_4};
    for (int i = 0; i < 3; i++) begin
      wr1(8'h10, {6'h00, sel[i]});
      period(0, n);
      check("sys period", n, i + 2);
    end
    wr1(8'h10, 8'h06);
    period(1, n);
    check("buf doubled", n, 2);
    host.send_bits(8'h80, 8);
    host.recv_byte(b);
    check("cfg read", b, 8'h06);
    host.recv_byte(b);
    check("cfg read 2", b, 8'h00);
    host.step(GAP + 5);
    check("data oe idle", dev_oe, 1'b0);
    $display("test divisor done");
  endtask

  // Laser on/off and dropped short byte
  task automatic t_laser();
    int c;
    c = wr_count;
    wr1(8'h14, 8'h01);
    check("beat count", wr_count, c + 1);
    check("beat", last_beat, {4'h4, 3'h0, 8'h01});
    check("laser on", laser_oe, 1'b0);
    host.send_bits(8'h14, 8);
    host.send_bits(8'h00, 7);
    host.step(GAP + 5);
    check("short dropped", wr_count, c + 1);
    check("laser still on", laser_oe, 1'b0);
    wr1(8'h14, 8'h00);
    check("laser off", laser_oe, 1'b1);
    $display("test laser done");
  endtask

  // Seven data bytes, then a command with no gap
  task automatic t_multi();
    int c;
    c = wr_count;
    host.send_bits(8'h71, 8);
    for (int i = 0; i < 7; i++) host.send_bits(8'h80 + 8'(i), 8);
    check("seven beats", wr_count, c + 7);
    check("last beat", last_beat, {4'h1, 3'h6, 8'h86});
    wr1(8'h14, 8'h01);
    check("next is cmd", laser_oe, 1'b0);
    $display("test multi done");
  endtask

  // Five read bytes, then early end
  task automatic t_read();
    logic [7:0] b;
    rd_bytes = 40'hA53C960FE1;
    host.send_bits(8'h81, 8);
    for (int i = 4; i >= 0; i--) begin
      host.recv_byte(b);
      check("read byte", b, rd_bytes[i*8 +: 8]);
    end
    wr1(8'h14, 8'h00);
    check("after five", laser_oe, 1'b1);
    host.send_bits(8'h82, 8);
    host.recv_byte(b);
    check("early read", b, 8'hA5);
    host.recv_byte(b);
    check("early read 2", b, 8'h3C);
    host.step(GAP + 5);
    wr1(8'h14, 8'h01);
    check("after early", laser_oe, 1'b0);
    $display("test read done");
  endtask

  // Mid level toggles at the tick rate; zero levels stay quiet
  task automatic t_rate();
    int     n;
    int     ones;
    longint exp;
    logic   prev;
    n = 0;
    ones = 0;
    wr1(8'h11, 8'h00);
    wr1(8'h13, 8'h00);
    prev = act[1];
    exp = longint'(servo_pkg::ACT_RATE_HZ) * 25000 / servo_pkg::CLK_HZ;
    repeat (25000) begin
      @(posedge core_clk);
      #2;
      if (act[1] !== prev) n++;
      if (act[0] !== 1'b0 || act[2] !== 1'b0) ones++;
      prev = act[1];
    end
    check("stream rate", (n >= exp - 2) && (n <= exp + 2), 1'b1);
    check("zero level quiet", ones, 0);
    $display("test rate done");
  endtask

  // Reset in mid-run restores defaults
  task automatic t_rst_mid();
    int n;
    wr1(8'h10, 8'h00);
    rst_n = 1'b0;
    host.step(3);
    check("act_oe mid", act_oe, 3'h0);
    check("laser mid", laser_oe, 1'b1);
    rst_n = 1'b1;
    host.step(3);
    period(0, n);
    check("sys period mid", n, 4);
    $display("test reset mid done");
  endtask

  // Counts and verdict
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    host.step(10);
    t_reset();
    t_divisor();
    t_laser();
    t_multi();
    t_read();
    t_rate();
    t_rst_mid();
    conclude();
  end

  // Watchdog
  initial begin
    #(5_000_000);
    fail_count++;
    conclude();
  end
endmodule
